// ==== verilog/pbat_pkg.sv ====
// Package of the peripheral bus access bridge: address windows, register widths,
// access cycle counts and bus select positions. Assumes nothing beyond SystemVerilog.
package pbat_pkg;

    // Target classes that the address decoder reports
    typedef enum logic [2:0] {
        PBAT_TGT_NONE,
        PBAT_TGT_INTREQ,
        PBAT_TGT_PB,
        PBAT_TGT_FLASH,
        PBAT_TGT_EXT,
        PBAT_TGT_EXTERR
    } pbat_tgt_e;

    // Address windows, first and last byte of each
    localparam logic [31:0] INTREQ_FIRST = 32'h0008_7000;
    localparam logic [31:0] INTREQ_LAST = 32'h0008_7FFF;
    localparam logic [31:0] PB_FIRST = 32'h0008_8000;
    localparam logic [31:0] PB_LAST = 32'h0008_BFFF;
    localparam logic [31:0] FLASH_FIRST = 32'h0008_C000;
    localparam logic [31:0] FLASH_LAST = 32'h0008_CFFF;
    localparam logic [31:0] EXT_FIRST = 32'h0008_1000;
    localparam logic [31:0] EXT_LAST = 32'h0008_12FF;
    localparam logic [31:0] EXTERR_FIRST = 32'h0008_1300;
    localparam logic [31:0] EXTERR_LAST = 32'h0008_13FF;
    // Word-wide registers inside the peripheral window
    localparam logic [31:0] W16A_FIRST = 32'h0008_B006;
    localparam logic [31:0] W16A_LAST = 32'h0008_B00B;
    localparam logic [31:0] W16B_FIRST = 32'h0008_B082;
    localparam logic [31:0] W16B_LAST = 32'h0008_B085;

    // Access size codes
    localparam logic [1:0] SIZE_8 = 2'h0;
    localparam logic [1:0] SIZE_16 = 2'h1;

    // Cycle counts; core-timed counts include the taking cycle
    localparam logic [1:0] CORE_ACC_CYC = 2'h2;
    localparam logic [1:0] PB_CYC_8 = 2'h2;
    localparam logic [1:0] PB_CYC_16 = 2'h3;
    localparam logic [1:0] FLASH_CYC = 2'h2;
    localparam logic [1:0] EXT_CYC = 2'h2;

    // Select vector: buses 1 to 6, then the external bus controller
    localparam int SEL_W = 7;
    localparam int SEL_BUS1 = 0;
    localparam int SEL_BUS2 = 1;
    localparam int SEL_BUS6 = 5;
    localparam int SEL_EXT = 6;

    // Divider ratio field width and reset value (divide by one)
    localparam int DIV_W = 6;
    localparam logic [5:0] DIV_RST = 6'h00;

endpackage

// ==== verilog/pbat_clk_en.sv ====
// Divided clock enable: one-cycle pulse every (i_div + 1) core cycles.
// Assumes i_div is a level from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module pbat_clk_en #(
    parameter int DW = pbat_pkg::DIV_W
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [DW-1:0] i_div,
    output logic o_en
);
    logic [DW-1:0] cnt_r;
    logic [DW-1:0] cnt_nxt;
    logic en_r;
    logic en_nxt;

    // Wrap the count at the ratio, pulse on wrap
    always_comb begin
        if (cnt_r >= i_div) begin
            cnt_nxt = '0;
        end else begin
            cnt_nxt = cnt_r + {{(DW-1){1'b0}}, 1'b1};
        end
        en_nxt = (cnt_nxt == '0);
    end

    // Register state
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= '0;
            en_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            en_r <= en_nxt;
        end
    end

    assign o_en = en_r;
endmodule
`default_nettype wire

// ==== verilog/pbat_addr_dec.sv ====
// Address decoder: target class, declared register width and peripheral cycle count.
// Assumes a stable address; purely combinational.
`timescale 1ns/100ps
`default_nettype none
module pbat_addr_dec (
    input wire logic [31:0] i_addr,
    output pbat_pkg::pbat_tgt_e o_tgt,
    output logic [1:0] o_size,
    output logic [1:0] o_pcyc
);
    // Inclusive window test
    function automatic logic in_win(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
        in_win = (a >= lo) && (a <= hi);
    endfunction

    logic wide;

    // Classify the address and look up width and cycles
    always_comb begin
        wide = in_win(i_addr, pbat_pkg::W16A_FIRST, pbat_pkg::W16A_LAST)
            || in_win(i_addr, pbat_pkg::W16B_FIRST, pbat_pkg::W16B_LAST);
        o_tgt = pbat_pkg::PBAT_TGT_NONE;
        o_size = pbat_pkg::SIZE_8;
        o_pcyc = pbat_pkg::CORE_ACC_CYC;
        if (in_win(i_addr, pbat_pkg::INTREQ_FIRST, pbat_pkg::INTREQ_LAST)) begin
            o_tgt = pbat_pkg::PBAT_TGT_INTREQ;
        end else if (in_win(i_addr, pbat_pkg::PB_FIRST, pbat_pkg::PB_LAST)) begin
            o_tgt = pbat_pkg::PBAT_TGT_PB;
            o_size = wide ? pbat_pkg::SIZE_16 : pbat_pkg::SIZE_8;
            o_pcyc = wide ? pbat_pkg::PB_CYC_16 : pbat_pkg::PB_CYC_8;
        end else if (in_win(i_addr, pbat_pkg::FLASH_FIRST, pbat_pkg::FLASH_LAST)) begin
            o_tgt = pbat_pkg::PBAT_TGT_FLASH;
            o_pcyc = pbat_pkg::FLASH_CYC;
        end else if (in_win(i_addr, pbat_pkg::EXT_FIRST, pbat_pkg::EXT_LAST)) begin
            o_tgt = pbat_pkg::PBAT_TGT_EXT;
            o_size = pbat_pkg::SIZE_16;
            o_pcyc = pbat_pkg::EXT_CYC;
        end else if (in_win(i_addr, pbat_pkg::EXTERR_FIRST, pbat_pkg::EXTERR_LAST)) begin
            o_tgt = pbat_pkg::PBAT_TGT_EXTERR;
            o_size = pbat_pkg::SIZE_16;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/pbat_bridge.sv ====
// Peripheral bus access bridge: main bus slave on the core clock, master of the
// peripheral buses and external bus controller registers on divided clock enables.
// Assumes a master that pulses I_REQ only while O_BUSY is low and peripherals that
// act on O_P_STB and return read data on I_P_RDATA in the same cycle.
//
// Operation
// RL1 - An access costs the main bus cycle, the synchronisation wait and the peripheral bus cycles of the target bus.
// RL2 - The peripheral bus cycle count is looked up per target register.
// RL3 - Synchronisation is waited for on buses 2 to 6 and external bus registers, but not on bus error registers.
// RL4 - The synchronisation wait depends on the clock ratio and on where the access falls against the enable.
// RL5 - With the core at least as fast, main bus plus synchronisation takes at most one peripheral or flash clock.
// RL6 - With the core slower, the access counts in core clocks and the next access may start right after completion.
// RL7 - For external bus registers main bus plus synchronisation takes at most one external bus clock.
// RL8 - Accesses are launched only when no other master or fetch contends for the peripheral side.
// RL9 - Interrupt request registers are byte wide and complete in 2 core clocks regardless of ratio.
// RL10 - Second peripheral clock registers take 2 or 3 of its cycles, or 2 core clocks when the core is slower.
// RL11 - Byte registers take byte accesses and word registers word accesses; others end in an error.
// RL12 - A write has taken effect before its completion is signalled, so a later read sees it.
// RL13 - The master is held busy until the peripheral access is done and its data registered.
`timescale 1ns/100ps
`default_nettype none
module pbat_bridge #(
    parameter int DW = pbat_pkg::DIV_W
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    input wire logic I_REQ,
    input wire logic [31:0] I_ADDR,
    input wire logic I_WE,
    input wire logic [1:0] I_SIZE,
    input wire logic [15:0] I_WDATA,
    output logic O_BUSY,
    output logic O_READY,
    output logic O_ERR,
    output logic [15:0] O_RDATA,
    input wire logic I_CONTEND,
    input wire logic I_CORE_SLOWER,
    input wire logic [DW-1:0] I_PERIPHERAL_CLOCK_B_DIV,
    input wire logic [DW-1:0] I_FLASH_INTERFACE_CLOCK_DIV,
    input wire logic [DW-1:0] I_BCLK_DIV,
    output logic [pbat_pkg::SEL_W-1:0] O_P_SEL,
    output logic O_P_STB,
    output logic [31:0] O_P_ADDR,
    output logic O_P_WE,
    output logic [1:0] O_P_SIZE,
    output logic [15:0] O_P_WDATA,
    input wire logic [15:0] I_P_RDATA
);
    typedef enum logic [2:0] {ST_IDLE, ST_ARB, ST_SYNC, ST_ACC, ST_DONE} pbat_st_e;

    pbat_st_e st_r, st_nxt;
    pbat_pkg::pbat_tgt_e tgt_r, tgt_nxt, dec_tgt;
    logic [31:0] addr_r, addr_nxt, dec_addr;
    logic we_r, we_nxt;
    logic [1:0] size_r, size_nxt, dec_size, dec_pcyc;
    logic [15:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
    logic [1:0] cnt_r, cnt_nxt, pcyc_r, pcyc_nxt;
    logic ct_r, ct_nxt, err_r, err_nxt;
    logic [pbat_pkg::SEL_W-1:0] sel_r, sel_nxt, sel_dec;
    logic en_peripheral_clock_b, en_flash_interface_clock, en_bclk;
    logic [DW-1:0] tdiv;
    logic take, launch, bad, need_sync, core_timed, ten, tick, stb;

    // Divided clock enables for peripheral, flash interface and external bus clocks
    pbat_clk_en #(.DW(DW)) u_en_peripheral_clock_b (
        .i_clk(I_CORE_CLK),
        .i_rst_n(I_RST_N),
        .i_div(I_PERIPHERAL_CLOCK_B_DIV),
        .o_en(en_peripheral_clock_b)
    );
    pbat_clk_en #(.DW(DW)) u_en_flash_interface_clock (
        .i_clk(I_CORE_CLK),
        .i_rst_n(I_RST_N),
        .i_div(I_FLASH_INTERFACE_CLOCK_DIV),
        .o_en(en_flash_interface_clock)
    );
    pbat_clk_en #(.DW(DW)) u_en_bclk (
        .i_clk(I_CORE_CLK),
        .i_rst_n(I_RST_N),
        .i_div(I_BCLK_DIV),
        .o_en(en_bclk)
    );

    // Decode the incoming address when taking, the held one otherwise
    assign take = I_REQ && ((st_r == ST_IDLE) || (st_r == ST_DONE));
    assign dec_addr = take ? I_ADDR : addr_r;
    pbat_addr_dec u_dec (
        .i_addr(dec_addr),
        .o_tgt(dec_tgt),
        .o_size(dec_size),
        .o_pcyc(dec_pcyc)
    );

    // Launch qualifiers for the decoded target
    always_comb begin
        bad = (dec_tgt == pbat_pkg::PBAT_TGT_NONE) || ((take ? I_SIZE : size_r) != dec_size); // see RL11
        need_sync = (dec_tgt == pbat_pkg::PBAT_TGT_EXT)                                       // see RL3, RL7
            || (((dec_tgt == pbat_pkg::PBAT_TGT_PB) || (dec_tgt == pbat_pkg::PBAT_TGT_FLASH)) && !I_CORE_SLOWER);
        core_timed = (dec_tgt == pbat_pkg::PBAT_TGT_INTREQ) || (dec_tgt == pbat_pkg::PBAT_TGT_EXTERR) // see RL9
            || (((dec_tgt == pbat_pkg::PBAT_TGT_PB) || (dec_tgt == pbat_pkg::PBAT_TGT_FLASH)) && I_CORE_SLOWER);
        sel_dec = '0;
        case (dec_tgt)
            pbat_pkg::PBAT_TGT_INTREQ: sel_dec[pbat_pkg::SEL_BUS1] = 1'b1;
            pbat_pkg::PBAT_TGT_PB: sel_dec[pbat_pkg::SEL_BUS2] = 1'b1;
            pbat_pkg::PBAT_TGT_FLASH: sel_dec[pbat_pkg::SEL_BUS6] = 1'b1;
            pbat_pkg::PBAT_TGT_EXT, pbat_pkg::PBAT_TGT_EXTERR: sel_dec[pbat_pkg::SEL_EXT] = 1'b1;
            default: sel_dec = '0;
        endcase
    end

    // Access pacing: core-timed accesses tick every cycle, others on the target enable
    always_comb begin
        tdiv = '0;
        case (tgt_r)
            pbat_pkg::PBAT_TGT_PB: begin
                ten = en_peripheral_clock_b;
                tdiv = I_PERIPHERAL_CLOCK_B_DIV;
            end
            pbat_pkg::PBAT_TGT_FLASH: begin
                ten = en_flash_interface_clock;
                tdiv = I_FLASH_INTERFACE_CLOCK_DIV;
            end
            pbat_pkg::PBAT_TGT_EXT: begin
                ten = en_bclk;
                tdiv = I_BCLK_DIV;
            end
            default: ten = 1'b1;
        endcase
        tick = ct_r ? 1'b1 : ten; // see RL4, RL6
        stb = (st_r == ST_ACC) && tick && (cnt_r == 2'h1);
    end

    // Access sequencer next state
    always_comb begin
        st_nxt = st_r;
        tgt_nxt = tgt_r;
        addr_nxt = addr_r;
        we_nxt = we_r;
        size_nxt = size_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        cnt_nxt = cnt_r;
        pcyc_nxt = pcyc_r;
        ct_nxt = ct_r;
        err_nxt = err_r;
        sel_nxt = sel_r;
        launch = 1'b0;
        case (st_r)
            ST_IDLE, ST_DONE: begin
                if (st_r == ST_DONE) begin
                    st_nxt = ST_IDLE;
                    sel_nxt = '0;
                end
                if (take) begin
                    addr_nxt = I_ADDR;
                    we_nxt = I_WE;
                    size_nxt = I_SIZE;
                    wdata_nxt = I_WDATA;
                    if (I_CONTEND) begin
                        st_nxt = ST_ARB; // see RL8
                    end else begin
                        launch = 1'b1;
                    end
                end
            end
            ST_ARB: begin
                launch = !I_CONTEND; // see RL8
            end
            ST_SYNC: begin
                if (ten) begin
                    st_nxt = ST_ACC; // see RL5, RL7
                    sel_nxt = sel_dec;
                end
            end
            ST_ACC: begin
                if (tick) begin
                    cnt_nxt = cnt_r - 2'h1; // see RL2
                    if (cnt_r == 2'h1) begin
                        st_nxt = ST_DONE; // see RL12, RL13
                        rdata_nxt = we_r ? 16'h0000 : I_P_RDATA;
                    end
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        if (launch) begin
            tgt_nxt = dec_tgt;
            ct_nxt = core_timed;
            err_nxt = bad;
            rdata_nxt = 16'h0000;
            if (bad) begin
                st_nxt = ST_DONE; // see RL11
                sel_nxt = '0;
            end else if (need_sync) begin
                st_nxt = ST_SYNC; // see RL3
                cnt_nxt = dec_pcyc; // see RL1, RL10
                pcyc_nxt = dec_pcyc;
            end else begin
                st_nxt = ST_ACC; // see RL9, RL10
                cnt_nxt = pbat_pkg::CORE_ACC_CYC - 2'h1;
                pcyc_nxt = pbat_pkg::CORE_ACC_CYC - 2'h1;
                sel_nxt = sel_dec;
            end
        end
    end

    // Register the sequencer
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            st_r <= ST_IDLE;
            tgt_r <= pbat_pkg::PBAT_TGT_NONE;
            addr_r <= 32'h0000_0000;
            we_r <= 1'b0;
            size_r <= pbat_pkg::SIZE_8;
            wdata_r <= 16'h0000;
            rdata_r <= 16'h0000;
            cnt_r <= 2'h0;
            pcyc_r <= 2'h0;
            ct_r <= 1'b0;
            err_r <= 1'b0;
            sel_r <= '0;
        end else begin
            st_r <= st_nxt;
            tgt_r <= tgt_nxt;
            addr_r <= addr_nxt;
            we_r <= we_nxt;
            size_r <= size_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            cnt_r <= cnt_nxt;
            pcyc_r <= pcyc_nxt;
            ct_r <= ct_nxt;
            err_r <= err_nxt;
            sel_r <= sel_nxt;
        end
    end

    // Main bus and peripheral bus outputs
    assign O_BUSY = (st_r == ST_ARB) || (st_r == ST_SYNC) || (st_r == ST_ACC); // see RL13
    assign O_READY = (st_r == ST_DONE);
    assign O_ERR = err_r;
    assign O_RDATA = rdata_r;
    assign O_P_SEL = sel_r;
    assign O_P_STB = stb; // see RL12
    assign O_P_ADDR = addr_r;
    assign O_P_WE = we_r;
    assign O_P_SIZE = size_r;
    assign O_P_WDATA = wdata_r;

    // Helper: ticks counted during the access phase
    logic [1:0] acc_ticks_r;
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            acc_ticks_r <= 2'h0;
        end else if (launch) begin
            acc_ticks_r <= 2'h0;
        end else if ((st_r == ST_ACC) && tick) begin
            acc_ticks_r <= acc_ticks_r + 2'h1;
        end
    end

    // Helper: cycles spent waiting for the target enable
    logic [DW-1:0] sync_cyc_r;
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            sync_cyc_r <= '0;
        end else if (st_r == ST_SYNC) begin
            sync_cyc_r <= sync_cyc_r + {{(DW-1){1'b0}}, 1'b1};
        end else begin
            sync_cyc_r <= '0;
        end
    end

    // Checks on timing and ordering
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);

    a_intr_two_cyc: assert property (take && !I_CONTEND && (dec_tgt == pbat_pkg::PBAT_TGT_INTREQ) // see RL9
        && (I_SIZE == pbat_pkg::SIZE_8) |-> ##1 !O_READY ##1 (O_READY && !O_ERR))
        else $error("interrupt request register access not done in 2 cycles");
    a_slow_core_two: assert property (take && !I_CONTEND && I_CORE_SLOWER // see RL6
        && (dec_tgt == pbat_pkg::PBAT_TGT_PB) && !bad |-> ##2 (O_READY && !O_ERR))
        else $error("slow core peripheral access not done in 2 core cycles");
    a_no_sync_exterr: assert property (launch && (dec_tgt == pbat_pkg::PBAT_TGT_EXTERR) && !bad // see RL3
        |=> (st_r == ST_ACC) && O_P_SEL[pbat_pkg::SEL_EXT])
        else $error("bus error register access waited for synchronisation");
    a_sync_on_en: assert property ((st_r == ST_SYNC) && ten |=> (st_r == ST_ACC) && (O_P_SEL != '0)) // see RL5
        else $error("synchronisation did not end on the target enable");
    a_sync_hold: assert property ((st_r == ST_SYNC) && !ten |=> (st_r == ST_SYNC) && (O_P_SEL == '0)) // see RL7
        else $error("peripheral selected before the target enable");
    a_ticks_match: assert property (O_READY && !O_ERR |-> acc_ticks_r == pcyc_r) // see RL2
        else $error("peripheral cycle count differs from the register value");
    a_size_err: assert property (launch && bad |=> O_READY && O_ERR && (O_P_SEL == '0)) // see RL11
        else $error("mismatched access size not refused");
    a_contend_hold: assert property ((st_r == ST_ARB) && I_CONTEND |=> (st_r == ST_ARB) && O_BUSY) // see RL8
        else $error("access launched during contention");
    a_write_done: assert property (O_READY && !O_ERR |-> $past(O_P_STB) && $past(O_BUSY)) // see RL12
        else $error("completion without a peripheral strobe");
    a_sel_onehot: assert property ((st_r == ST_ACC) |-> $onehot(O_P_SEL)) // see RL1
        else $error("peripheral select not one-hot during access");
    a_sync_bound: assert property ((st_r == ST_SYNC) |-> (sync_cyc_r <= tdiv)) // see RL5, RL7
        else $error("synchronisation wait longer than one divided clock");
    a_slow_flash_two: assert property (take && !I_CONTEND && I_CORE_SLOWER // see RL6
        && (dec_tgt == pbat_pkg::PBAT_TGT_FLASH) && !bad |-> ##2 (O_READY && !O_ERR))
        else $error("slow core flash interface access not done in 2 core cycles");

    c_intr_read: cover property (take && (dec_tgt == pbat_pkg::PBAT_TGT_INTREQ) ##2 O_READY);
    c_sync_wait: cover property ((st_r == ST_SYNC) ##1 (st_r == ST_SYNC));
    c_pb_word: cover property (O_P_STB && (O_P_SIZE == pbat_pkg::SIZE_16) ##1 O_READY);
    c_contend: cover property ((st_r == ST_ARB) ##1 (st_r == ST_SYNC));
    c_error: cover property (O_READY && O_ERR);
endmodule
`default_nettype wire

// ==== verification/pbat_periph_model.sv ====
// Peripheral side model: register storage behind the bridge's peripheral bus.
// Assumes writes land at the strobe edge and that reads are sampled in the strobe cycle.
`timescale 1ns/100ps
`default_nettype none
module pbat_periph_model (
    input wire logic i_clk,
    input wire logic [6:0] i_sel,
    input wire logic i_stb,
    input wire logic [31:0] i_addr,
    input wire logic i_we,
    input wire logic [1:0] i_size,
    input wire logic [15:0] i_wdata,
    output logic [15:0] o_rdata
);
    logic [15:0] mem [0:4095];
    logic [15:0] last_r;
    // Storage starts cleared
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 16'h0000;
        end
        last_r = 16'h0000;
    end
    // Write lands at the strobe edge; a byte write keeps only the low byte
    always @(posedge i_clk) begin
        if (i_stb && i_we) begin
            mem[i_addr[11:0]] <= (i_size == pbat_pkg::SIZE_8) ? {8'h00, i_wdata[7:0]} : i_wdata;
        end
        if (i_sel != 7'h00) begin
            last_r <= o_rdata;
        end
    end
    // Deselected bus shows the inverse of the last value, never a held copy
    assign o_rdata = (i_sel != 7'h00) ? mem[i_addr[11:0]] : ~last_r;
endmodule
`default_nettype wire

// ==== verification/pbat_bridge_tb_top.sv ====
// Testbench of the peripheral bus access bridge: latency, select, error and data checks.
// Assumes the bridge package and the peripheral side model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin \
    $display("unexpected %s expected %0h seen %0h", nm, ex, gt); fail_count++; end end
module pbat_bridge_tb_top;
    logic clk, rst_n, req, we, contend, slower, stb, busy, ready, err, pwe;
    logic [31:0] addr, paddr;
    logic [1:0] size, psize;
    logic [15:0] wdata, rdata, pwdata, prdata;
    logic [5:0] pdiv, fdiv, bdiv;
    logic [6:0] sel, selor;
    logic err_s, bsy_s;
    logic [15:0] rd_s;
    int lat, nstb, lb, fail_count, samples_checked, cyc;

    pbat_bridge DUT (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_REQ(req), .I_ADDR(addr), .I_WE(we),
        .I_SIZE(size), .I_WDATA(wdata), .O_BUSY(busy), .O_READY(ready), .O_ERR(err), .O_RDATA(rdata),
        .I_CONTEND(contend), .I_CORE_SLOWER(slower), .I_PERIPHERAL_CLOCK_B_DIV(pdiv),
        .I_FLASH_INTERFACE_CLOCK_DIV(fdiv), .I_BCLK_DIV(bdiv), .O_P_SEL(sel), .O_P_STB(stb), .O_P_ADDR(paddr),
        .O_P_WE(pwe), .O_P_SIZE(psize), .O_P_WDATA(pwdata), .I_P_RDATA(prdata));
    pbat_periph_model periph (.i_clk(clk), .i_sel(sel), .i_stb(stb), .i_addr(paddr), .i_we(pwe),
        .i_size(psize), .i_wdata(pwdata), .o_rdata(prdata));

    // Core clock, 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One access; lat counts cycles from the taking edge to the ready cycle
    task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] s, input logic [15:0] d);
        @(posedge clk);
        req <= 1'b1;
        addr <= a;
        we <= w;
        size <= s;
        wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        selor = 7'h00;
        nstb = 0;
        for (lat = 1; lat < 100; lat++) begin
            @(negedge clk);
            selor = selor | sel;
            if (lat == 1) bsy_s = busy;
            if (stb === 1'b1) nstb++;
            if (ready === 1'b1) break;
        end
        err_s = err;
        rd_s = rdata;
    endtask

    // Interrupt request registers: byte access in two core clocks, word access refused
    task automatic t_intreq();
        @(posedge clk);
        pdiv <= 6'h07;
        acc(32'h0008_7076, 1'b1, pbat_pkg::SIZE_8, 16'h00A5);
        `CHK("intreq_wr_lat", 2, lat)
        `CHK("intreq_sel", 7'h01, selor)
        `CHK("intreq_busy", 1'b1, bsy_s)
        acc(32'h0008_7076, 1'b0, pbat_pkg::SIZE_8, 16'h0000);
        `CHK("intreq_rd_lat", 2, lat)
        `CHK("intreq_rd_data", 16'h00A5, rd_s)
        acc(32'h0008_7076, 1'b0, pbat_pkg::SIZE_16, 16'h0000);
        `CHK("intreq_word_err", 1'b1, err_s)
        `CHK("intreq_word_lat", 1, lat)
        `CHK("intreq_word_stb", 0, nstb)
        `CHK("intreq_word_busy", 1'b0, bsy_s)
        $display("test interrupt request done");
    endtask

    // Second peripheral bus: byte and word counts differ, data round trip, slow divider bound
    task automatic t_pb();
        @(posedge clk);
        pdiv <= 6'h00;
        acc(32'h0008_B000, 1'b0, pbat_pkg::SIZE_8, 16'h0000);
        lb = lat;
        `CHK("pb_sel", 7'h02, selor)
        acc(32'h0008_B006, 1'b1, pbat_pkg::SIZE_16, 16'h1234);
        `CHK("pb_word_extra", 1, lat - lb)
        `CHK("pb_word_err", 1'b0, err_s)
        acc(32'h0008_B006, 1'b0, pbat_pkg::SIZE_16, 16'h0000);
        `CHK("pb_word_data", 16'h1234, rd_s)
        acc(32'h0008_B000, 1'b0, pbat_pkg::SIZE_16, 16'h0000);
        `CHK("pb_size_err", 1'b1, err_s)
        @(posedge clk);
        pdiv <= 6'h03;
        acc(32'h0008_A160, 1'b1, pbat_pkg::SIZE_8, 16'h005A);
        `CHK("pb_div_lat_ok", 1'b1, (lat >= 5 && lat <= 13))
        `CHK("pb_div_stb", 1, nstb)
        $display("test peripheral bus done");
    endtask

    // Core slower than peripheral clock: counts in core clocks; then a flash access with the core faster
    task automatic t_slow();
        @(posedge clk);
        slower <= 1'b1;
        pdiv <= 6'h05;
        fdiv <= 6'h05;
        acc(32'h0008_A160, 1'b0, pbat_pkg::SIZE_8, 16'h0000);
        `CHK("slow_pb_lat", 2, lat)
        `CHK("slow_pb_data", 16'h005A, rd_s)
        acc(32'h0008_C000, 1'b0, pbat_pkg::SIZE_8, 16'h0000);
        `CHK("slow_flash_lat", 2, lat)
        `CHK("slow_flash_sel", 7'h20, selor)
        @(posedge clk);
        slower <= 1'b0;
        fdiv <= 6'h01;
        acc(32'h0008_C000, 1'b0, pbat_pkg::SIZE_8, 16'h0000);
        `CHK("flash_lat_ok", 1'b1, (lat >= 3 && lat <= 7))
        $display("test slow core done");
    endtask

    // External bus registers: synced within one bus clock, error registers exempt
    task automatic t_ext();
        @(posedge clk);
        bdiv <= 6'h03;
        acc(32'h0008_1000, 1'b1, pbat_pkg::SIZE_16, 16'hBEEF);
        `CHK("ext_lat_ok", 1'b1, (lat >= 5 && lat <= 13))
        `CHK("ext_sel", 7'h40, selor)
        acc(32'h0008_1300, 1'b0, pbat_pkg::SIZE_16, 16'h0000);
        `CHK("ext_err_reg_lat", 2, lat)
        $display("test external bus done");
    endtask

    // Contention delays the launch by the cycles it stays high
    task automatic t_contend();
        fork
            acc(32'h0008_7080, 1'b0, pbat_pkg::SIZE_8, 16'h0000);
            begin
                @(posedge clk);
                contend <= 1'b1;
                repeat (3) @(posedge clk);
                contend <= 1'b0;
            end
        join
        `CHK("contend_lat", 5, lat)
        $display("test contention done");
    endtask

    // Request held through busy is ignored, retaken in the ready cycle; unmapped address refused
    task automatic t_b2b();
        int rdy_at [2];
        int k;
        k = 0;
        @(posedge clk);
        req <= 1'b1;
        addr <= 32'h0008_7090;
        we <= 1'b0;
        size <= pbat_pkg::SIZE_8;
        nstb = 0;
        for (int c = 0; c < 8; c++) begin
            @(negedge clk);
            if (stb === 1'b1) nstb++;
            if (ready === 1'b1 && k < 2) begin
                rdy_at[k] = c;
                k++;
            end
            @(posedge clk);
            if (c == 2) req <= 1'b0;
        end
        `CHK("b2b_first", 2, rdy_at[0])
        `CHK("b2b_second", 4, rdy_at[1])
        `CHK("b2b_stb", 2, nstb)
        acc(32'h0008_0000, 1'b0, pbat_pkg::SIZE_8, 16'h0000);
        `CHK("unmapped_err", 1'b1, err_s)
        `CHK("unmapped_stb", 0, nstb)
        $display("test back to back done");
    endtask

    // Main sequence
    initial begin
        {rst_n, req, we, contend, slower} = 5'h00;
        addr = 32'h0000_0000;
        size = 2'h0;
        wdata = 16'h0000;
        pdiv = 6'h00;
        fdiv = 6'h00;
        bdiv = 6'h00;
        fail_count = 0;
        samples_checked = 0;
        cyc = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_intreq();
        t_pb();
        t_slow();
        t_ext();
        t_contend();
        t_b2b();
        complete_run();
    end
endmodule
`undef CHK
`default_nettype wire
